// ### tx_hdlc_channel_provision_data.v
// Transmit HDLC channel provisioning data staging registers
//
// Behaviour
// - Register B at 0x388: length bits 10..0, controls bits 15..12, upper unused.
// - Register B length and reserved bits write-only; four control bits read/write.
// - No partial byte writes; any enabled lane updates every bit.
// - All byte lanes disabled means no register changes.
// - Length field is 16-byte block count minus one, from FIFO start block.
// - FCS diagnose bit set inverts every appended FCS bit.
// - Stream inversion bit set inverts the whole outgoing bit stream.
// - Expedite-inhibit set allows only normal data requests.
// - Seven-bit mode forces last bit of every octet to fill value.
// - Seven-bit mode clear sends all eight bits; fill value ignored.
// - Read/write fields return last write until an indirect read loads them.
// - Register C at 0x38C: transfer, flags, level, idle, start mode.
// - Register C read/write except bits 13, 12 and 4, which read as zero; loaded on indirect read completion.
// - Defined fields reset to zero.
// - Idle-fill low sends flags between packets; high sends all-ones.
// - Flag count code n gives two-to-the-n minimum flags.
`timescale 1ns/1ps
`include "txprov_defs.vh"
module tx_hdlc_channel_provision_data (
	sys_clk,
	rst,
	clk_en,
	reg_addr,
	reg_wr,
	reg_rd,
	byte_lane_enables,
	reg_wdata,
	reg_rdata,
	ind_read_done,
	ind_read_data_b,
	ind_read_data_c,
	fifo_block_count_m1,
	fcs_diag_flip,
	stream_invert,
	expedite_inhibit,
	seven_bit_octet_mode,
	request_block_count,
	min_flag_code,
	min_flag_count,
	start_level,
	idle_fill_ones,
	start_level_mode
);
	parameter AW = 12;
	input wire sys_clk;
	input wire rst;
	input wire clk_en;
	input wire [AW-1:0] reg_addr;
	input wire reg_wr;
	input wire reg_rd;
	input wire [3:0] byte_lane_enables;
	input wire [31:0] reg_wdata;
	output reg [31:0] reg_rdata;
	input wire ind_read_done;
	input wire [15:0] ind_read_data_b;
	input wire [15:0] ind_read_data_c;
	output reg [10:0] fifo_block_count_m1;
	output reg fcs_diag_flip;
	output reg stream_invert;
	output reg expedite_inhibit;
	output reg seven_bit_octet_mode;
	output reg [3:0] request_block_count;
	output reg [2:0] min_flag_code;
	output reg [7:0] min_flag_count;
	output reg [3:0] start_level;
	output reg idle_fill_ones;
	output reg start_level_mode;

	// ****************************************
	// Address decode
	// ****************************************
	wire hit_b;
	wire hit_c;
	wire [AW-1:0] off_b = `PROV_OFF_B;
	wire [AW-1:0] off_c = `PROV_OFF_C;

	// Writes qualified per register here; reads are decoded with the read-back path
	byte_lane_gate #(.AW(AW)) u_gate_b (
		.wr_en(reg_wr),
		.byte_lane_enables(byte_lane_enables),
		.addr(reg_addr),
		.match_addr(off_b),
		.hit(hit_b)
	);
	byte_lane_gate #(.AW(AW)) u_gate_c (
		.wr_en(reg_wr),
		.byte_lane_enables(byte_lane_enables),
		.addr(reg_addr),
		.match_addr(off_c),
		.hit(hit_c)
	);

	// Power-of-two flag minimum, 1 to 128
	// Shared by the reset and run paths so both agree on code zero
	function [7:0] flag_min;
		input [2:0] code;
		begin
			flag_min = `FLAG_MIN_ONE << code;
		end
	endfunction

	// ****************************************
	// Staging registers
	// ****************************************
	reg [15:0] data_b_ff;
	reg [15:0] data_c_ff;
	reg [15:0] nxt_data_b;
	reg [15:0] nxt_data_c;

	always @* begin
		nxt_data_b = data_b_ff;
		nxt_data_c = data_c_ff;
		// Indirect read only refreshes readable fields; write-only length stays staged
		if (ind_read_done) begin
			nxt_data_b = (data_b_ff & ~`B_RW_MASK) | (ind_read_data_b & `B_RW_MASK);
			nxt_data_c = ind_read_data_c & `C_RW_MASK;
		end
		// Host write in same cycle wins: software intent is newest
		if (hit_b) begin
			nxt_data_b = reg_wdata[15:0];
		end
		if (hit_c) begin
			nxt_data_c = reg_wdata[15:0] & `C_RW_MASK;
		end
	end

	// Clock enable low holds the staged word, even against an indirect load
	always @(posedge sys_clk) begin
		if (rst) begin
			data_b_ff <= `PROV_RESET;
			data_c_ff <= `PROV_RESET;
		end else if (clk_en) begin
			data_b_ff <= nxt_data_b;
			data_c_ff <= nxt_data_c;
		end
	end

	// ****************************************
	// Read-back path
	// ****************************************
	// Reset image of the staged word; outputs reset through the same field slices
	// Upper half is registered too but only ever loads UNUSED_READ; it reads as a constant
	wire [15:0] reset_word = `PROV_RESET;
	wire rd_b;
	wire rd_c;
	wire [15:0] rd_word;

	// One register addressed: strobe, at least one lane, exact offset
	function reg_hit;
		input strobe;
		input [3:0] lanes;
		input [AW-1:0] addr;
		input [AW-1:0] match;
		begin
			reg_hit = strobe && (|lanes) && (addr == match);
		end
	endfunction

	// All lanes off is no access at all, for reads as for writes
	// Reads have no side effect, so a decode is all they need
	assign rd_b = reg_hit(reg_rd, byte_lane_enables, reg_addr, off_b);
	assign rd_c = reg_hit(reg_rd, byte_lane_enables, reg_addr, off_c);

	// Write-only length and reserved bits read as zero; unmapped reads as zero
	assign rd_word = rd_b ? (nxt_data_b & `B_RW_MASK) :
		(rd_c ? nxt_data_c : `PROV_RESET);

	// Read data stands until the next clock-enabled edge, then the bus sees zero again,
	// so a late sampler reads zero rather than stale data
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= {`UNUSED_READ, reset_word};
		end else if (clk_en) begin
			reg_rdata <= {`UNUSED_READ, rd_word};
		end
	end

	// ****************************************
	// Settings outputs
	// ****************************************
	// Taken from the next staged value, so settings move on the same edge as
	// the staging flops; costs one mux level ahead of the output flops
	always @(posedge sys_clk) begin
		if (rst) begin
			fifo_block_count_m1 <= reset_word[`B_FIFO_BLOCK_COUNT_M1_MSB:`B_FIFO_BLOCK_COUNT_M1_LSB];
			fcs_diag_flip <= reset_word[`B_FCS_BIT];
			stream_invert <= reset_word[`B_INV_BIT];
			expedite_inhibit <= reset_word[`B_EXP_BIT];
			seven_bit_octet_mode <= reset_word[`B_SEVEN_BIT];
			request_block_count <= reset_word[`C_REQUEST_BLOCK_COUNT_MSB:`C_REQUEST_BLOCK_COUNT_LSB];
			min_flag_code <= reset_word[`C_FLAG_MSB:`C_FLAG_LSB];
			// Code zero still means one flag, not none
			min_flag_count <= flag_min(reset_word[`C_FLAG_MSB:`C_FLAG_LSB]);
			start_level <= reset_word[`C_LEVEL_MSB:`C_LEVEL_LSB];
			idle_fill_ones <= reset_word[`C_IDLE_BIT];
			start_level_mode <= reset_word[`C_START_LEVEL_MODE_BIT];
		end else if (clk_en) begin
			// Register B controls
			fifo_block_count_m1 <= nxt_data_b[`B_FIFO_BLOCK_COUNT_M1_MSB:`B_FIFO_BLOCK_COUNT_M1_LSB];
			fcs_diag_flip <= nxt_data_b[`B_FCS_BIT];
			stream_invert <= nxt_data_b[`B_INV_BIT];
			expedite_inhibit <= nxt_data_b[`B_EXP_BIT];
			seven_bit_octet_mode <= nxt_data_b[`B_SEVEN_BIT];
			// Register C controls
			request_block_count <= nxt_data_c[`C_REQUEST_BLOCK_COUNT_MSB:`C_REQUEST_BLOCK_COUNT_LSB];
			min_flag_code <= nxt_data_c[`C_FLAG_MSB:`C_FLAG_LSB];
			min_flag_count <= flag_min(nxt_data_c[`C_FLAG_MSB:`C_FLAG_LSB]);
			start_level <= nxt_data_c[`C_LEVEL_MSB:`C_LEVEL_LSB];
			idle_fill_ones <= nxt_data_c[`C_IDLE_BIT];
			start_level_mode <= nxt_data_c[`C_START_LEVEL_MODE_BIT];
		end
	end
endmodule // tx_hdlc_channel_provision_data

// ### txprov_defs.vh
// Constants for the transmit channel provisioning data registers
`ifndef TXPROV_DEFS_VH
`define TXPROV_DEFS_VH

`define PROV_OFF_B 12'h388
`define PROV_OFF_C 12'h38c

`define B_FIFO_BLOCK_COUNT_M1_MSB 10
`define B_FIFO_BLOCK_COUNT_M1_LSB 0
`define B_RSVD_BIT 11
`define B_FCS_BIT 12
`define B_INV_BIT 13
`define B_EXP_BIT 14
`define B_SEVEN_BIT 15

`define C_REQUEST_BLOCK_COUNT_MSB 3
`define C_REQUEST_BLOCK_COUNT_LSB 0
`define C_FLAG_MSB 7
`define C_FLAG_LSB 5
`define C_LEVEL_MSB 11
`define C_LEVEL_LSB 8
`define C_IDLE_BIT 14
`define C_START_LEVEL_MODE_BIT 15

`define B_RW_MASK 16'hf000
`define C_RW_MASK 16'hcfef
`define PROV_RESET 16'h0000
`define UNUSED_READ 16'h0000
`define FLAG_MIN_ONE 8'h01

`endif

// ### byte_lane_gate.v
// Qualifies a register write: any enabled byte lane writes the whole word
`timescale 1ns/1ps
module byte_lane_gate (
	wr_en,
	byte_lane_enables,
	addr,
	match_addr,
	hit
);
	parameter AW = 12;
	input wire wr_en;
	input wire [3:0] byte_lane_enables;
	input wire [AW-1:0] addr;
	input wire [AW-1:0] match_addr;
	output wire hit;

	// No partial writes; all lanes off means no access at all
	assign hit = wr_en && (|byte_lane_enables) && (addr == match_addr);
endmodule // byte_lane_gate

// ### tx_prov_sva.sv
// Checker for the provisioning data registers
`timescale 1ns/1ps
module tx_prov_sva #(parameter AW = 12) (
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	input wire [AW-1:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] byte_lane_enables,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire ind_read_done,
	input wire [15:0] ind_read_data_b,
	input wire fcs_diag_flip,
	input wire [2:0] min_flag_code,
	input wire [7:0] min_flag_count,
	input wire [3:0] start_level
);
	wire ln = clk_en && |byte_lane_enables;
	wire rd = ln && reg_rd;
	wire wb = ln && reg_wr && reg_addr == 12'h388;
	wire wc = ln && reg_wr && reg_addr == 12'h38c;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_flag_pow: assert property (min_flag_count == 8'h01 << min_flag_code)
		else $error("flag count");
	a_fcs_wr: assert property (wb |=> fcs_diag_flip == $past(reg_wdata[12]))
		else $error("fcs write");
	a_lvl_wr: assert property (wc |=> start_level == $past(reg_wdata[11:8]))
		else $error("level write");
	a_no_lane: assert property (reg_wr && !byte_lane_enables && !ind_read_done
		|=> $stable(start_level) && $stable(fcs_diag_flip)) else $error("lanes off");
	a_rd_b: assert property (rd && reg_addr == 12'h388 |=> !(reg_rdata & 32'hffff0fff))
		else $error("b read");
	a_rd_c: assert property (rd && !reg_wr && reg_addr == 12'h38c
		|=> !(reg_rdata & 32'hffff3010) && reg_rdata[11:8] == start_level) else $error("c read");
	a_rd_idle: assert property (clk_en && !rd |=> reg_rdata == 0)
		else $error("idle read");
	a_ind_ld: assert property (ind_read_done && clk_en && !reg_wr
		|=> fcs_diag_flip == $past(ind_read_data_b[12])) else $error("load");
endmodule // tx_prov_sva
bind tx_hdlc_channel_provision_data tx_prov_sva #(.AW(AW)) chk_i (
	.sys_clk(sys_clk),
	.rst(rst),
	.clk_en(clk_en),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.byte_lane_enables(byte_lane_enables),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.ind_read_done(ind_read_done),
	.ind_read_data_b(ind_read_data_b),
	.fcs_diag_flip(fcs_diag_flip),
	.min_flag_code(min_flag_code),
	.min_flag_count(min_flag_count),
	.start_level(start_level)
);

// ### prov_mem_model.sv
// Stored channel settings answering an indirect read
`timescale 1ns/1ps
module prov_mem_model #(parameter logic [15:0] B_VAL = 16'h5000, C_VAL = 16'h8a63) (
	input wire sys_clk,
	input wire trig,
	output logic done = 0,
	output logic [15:0] bo = 0,
	output logic [15:0] co = 0
);
	// Data toggles outside the done pulse so a late sample is caught
	always @(posedge sys_clk) begin
		done <= trig;
		bo <= trig ? B_VAL : ~bo;
		co <= trig ? C_VAL : ~co;
	end
endmodule // prov_mem_model

// ### tb_top.sv
// Testbench for the provisioning data registers
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, trig = 0, ind_read_done;
	logic [11:0] reg_addr = 0;
	logic [3:0] byte_lane_enables = 0, request_block_count, start_level;
	logic [31:0] reg_wdata = 0, reg_rdata, rv;
	logic [15:0] ind_read_data_b, ind_read_data_c;
	logic [10:0] fifo_block_count_m1;
	logic [7:0] min_flag_count;
	logic [2:0] min_flag_code;
	logic fcs_diag_flip, stream_invert, expedite_inhibit, seven_bit_octet_mode;
	logic idle_fill_ones, start_level_mode;
	logic [27:0] all_set;
	assign all_set = {fifo_block_count_m1, seven_bit_octet_mode, expedite_inhibit, stream_invert,
		fcs_diag_flip, request_block_count, min_flag_code, start_level, idle_fill_ones,
		start_level_mode};
	int err_count = 0, checks = 0, cyc = 0;
	always #4 sys_clk = ~sys_clk;
	tx_hdlc_channel_provision_data dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.byte_lane_enables(byte_lane_enables),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.ind_read_done(ind_read_done),
		.ind_read_data_b(ind_read_data_b),
		.ind_read_data_c(ind_read_data_c),
		.fifo_block_count_m1(fifo_block_count_m1),
		.fcs_diag_flip(fcs_diag_flip),
		.stream_invert(stream_invert),
		.expedite_inhibit(expedite_inhibit),
		.seven_bit_octet_mode(seven_bit_octet_mode),
		.request_block_count(request_block_count),
		.min_flag_code(min_flag_code),
		.min_flag_count(min_flag_count),
		.start_level(start_level),
		.idle_fill_ones(idle_fill_ones),
		.start_level_mode(start_level_mode)
	);
	prov_mem_model mem (.sys_clk, .trig, .done(ind_read_done), .bo(ind_read_data_b),
		.co(ind_read_data_c));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [11:0] a, input logic [3:0] l, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		byte_lane_enables <= l;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
		rv = reg_rdata;
	endtask
	task t_reg_b;
		#1;
		chk(all_set, 0);
		chk(min_flag_count, 1);
		acc(0, 12'h388, 4'hf, 0);
		chk(rv, 0);
		acc(1, 12'h388, 4'h1, 32'hffff_f7ff);
		chk(fifo_block_count_m1, 11'h7ff);
		acc(1, 12'h388, 4'h0, 0);
		acc(1, 12'h390, 4'hf, 0);
		chk({seven_bit_octet_mode, expedite_inhibit, stream_invert, fcs_diag_flip}, 4'hf);
		chk(fifo_block_count_m1, 11'h7ff);
		acc(0, 12'h388, 4'h0, 0);
		chk(rv, 0);
		acc(0, 12'h388, 4'h8, 0);
		chk(rv, 32'h0000_f000);
	endtask
	task t_reg_c;
		logic [31:0] d;
		for (int n = 0; n < 8; n++) begin
			d = 32'hffff_fa15 | (n << 5);
			acc(1, 12'h38c, 4'h2, d);
			chk(min_flag_count, 8'h01 << n);
			acc(0, 12'h38c, 4'h4, 0);
			chk(rv, d & 32'h0000_cfef);
		end
		chk({start_level_mode, idle_fill_ones, start_level, request_block_count}, 10'h3a5);
	endtask
	task t_ind_read;
		@(posedge sys_clk);
		trig <= 1;
		@(posedge sys_clk);
		trig <= 0;
		@(posedge sys_clk);
		#1;
		chk({seven_bit_octet_mode, expedite_inhibit, stream_invert, fcs_diag_flip}, 4'h5);
		chk(fifo_block_count_m1, 11'h7ff);
		acc(0, 12'h38c, 4'h1, 0);
		chk(rv, 32'h0000_8a63);
	endtask
	task t_freeze;
		@(posedge sys_clk);
		clk_en <= 0;
		acc(1, 12'h388, 4'hf, 32'h0000_0000);
		chk({seven_bit_octet_mode, expedite_inhibit, stream_invert, fcs_diag_flip}, 4'h5);
		@(posedge sys_clk);
		clk_en <= 1;
		acc(1, 12'h388, 4'h4, 32'h0000_a123);
		chk({seven_bit_octet_mode, expedite_inhibit, stream_invert, fcs_diag_flip}, 4'ha);
		chk(fifo_block_count_m1, 11'h123);
	endtask
	task t_reset;
		@(posedge sys_clk);
		rst <= 1;
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		#1;
		chk(all_set, 0);
		chk(min_flag_count, 1);
		acc(0, 12'h38c, 4'hf, 0);
		chk(rv, 0);
	endtask
	task complete_run;
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 0;
		t_reg_b;
		t_reg_c;
		t_ind_read;
		t_freeze;
		t_reset;
		complete_run;
	end
endmodule // tb_top
